// ### prt_timer.sv
// Periodic timer: 10-bit counter, compare A and P, four output modes, APB registers
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module prt_timer
   import prt_pkg::*;
(
   input wire logic clk_in,              // 250 MHz clock
   input wire logic reset_n_in,          // Async reset, active low
   input wire logic psel_in,             // APB select
   input wire logic penable_in,          // APB enable
   input wire logic pwrite_in,           // APB write
   input wire logic [7:0] paddr_in,      // APB byte address
   input wire logic [31:0] pwdata_in,    // APB write data
   output logic [31:0] prdata_out,       // APB read data
   output logic pready_out,              // APB ready
   output logic pslverr_out,             // APB error on unmapped address
   input wire logic tick_in,             // Selected timer clock tick, one cycle
   input wire logic ext_pin_in,          // External start pin level; a rising edge starts the single pulse
   output logic out_pin_out,             // Timer output pin level
   output logic out_en_out,              // Timer output pin drive enable
   output logic flag_a_out,              // Compare A flag
   output logic flag_p_out               // Compare P flag
);
   logic rst_meta_q;
   logic rst_n_q;
   prt_ctrl_t ctrl_q, ctrl_d;
   logic on_q, on_d;
   logic on_prev_q, on_prev_d;
   logic ext_prev_q, ext_prev_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [CW-1:0] a_q, a_d;
   logic [CW-1:0] p_q, p_d;
   logic af_q, af_d;
   logic pf_q, pf_d;
   logic pin_q, pin_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic out_q, out_d;
   logic oe_q, oe_d;
   logic setup, wr, on_rise, run, am, pm, single, pwm, cmp_like, ext_edge, raw, full;
   logic [CW-1:0] nxt;

   // Reset is released through two flops so deassertion is clean
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Bus strobes; the slave answers in the first access cycle with no wait states
   assign setup = psel_in & ~penable_in;
   assign wr = psel_in & penable_in & pready_q & pwrite_in;

   // Bus answer group
   always_comb
   begin
      prdata_d = prdata_q;
      pready_d = setup;
      pslverr_d = 1'b0;
      // Register read, captured in the setup cycle so access needs no wait
      if (setup)
      begin
         prdata_d = 32'h0000_0000;
         unique case (paddr_in)
            OFS_CTRL0: prdata_d[ON_BIT] = on_q;
            OFS_CTRL1: prdata_d[7:0] = ctrl_q;
            OFS_CNT_LO: prdata_d[7:0] = cnt_q[7:0];
            OFS_CNT_HI: prdata_d[1:0] = cnt_q[9:8];
            OFS_A_LO: prdata_d[7:0] = a_q[7:0];
            OFS_A_HI: prdata_d[1:0] = a_q[9:8];
            OFS_P_LO: prdata_d[7:0] = p_q[7:0];
            OFS_P_HI: prdata_d[1:0] = p_q[9:8];
            OFS_FLAGS:
            begin
               prdata_d[AF_BIT] = af_q;
               prdata_d[PF_BIT] = pf_q;
            end
            default: pslverr_d = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Timer state group
   always_comb
   begin
      ctrl_d = ctrl_q;
      on_d = on_q;
      a_d = a_q;
      p_d = p_q;
      af_d = af_q;
      pf_d = pf_q;
      cnt_d = cnt_q;
      pin_d = pin_q;
      on_prev_d = on_q;
      ext_prev_d = ext_pin_in;
      if (wr)
      begin
         unique case (paddr_in)
            OFS_CTRL0: on_d = pwdata_in[ON_BIT];
            OFS_CTRL1: ctrl_d = pwdata_in[7:0];
            OFS_A_LO: a_d[7:0] = pwdata_in[7:0];
            OFS_A_HI: a_d[9:8] = pwdata_in[1:0];
            OFS_P_LO: p_d[7:0] = pwdata_in[7:0];
            OFS_P_HI: p_d[9:8] = pwdata_in[1:0];
            OFS_FLAGS:
            begin
               // Write one to clear; a hardware set below still wins
               af_d = af_q & ~pwdata_in[AF_BIT];
               pf_d = pf_q & ~pwdata_in[PF_BIT];
            end
            default: ;
         endcase
      end
      cmp_like = ctrl_q.mode_field != MODE_PWM;
      pwm = (ctrl_q.mode_field == MODE_PWM) & (ctrl_q.output_function_field != FN_PULSE);
      single = (ctrl_q.mode_field == MODE_PWM) & (ctrl_q.output_function_field == FN_PULSE);
      on_rise = on_q & ~on_prev_q;
      run = on_q & ~on_rise & tick_in;
      nxt = cnt_q + CNT_ONE;
      // Match on the count about to be reached; P of zero matches at the wrap
      pm = run & (nxt == p_q);
      am = run & (nxt == a_q) & (~cmp_like | (a_q != CMP_RESET));
      ext_edge = single & ext_pin_in & ~ext_prev_q;
      if (on_rise)
      begin
         cnt_d = CNT_RESET;
         pin_d = ctrl_q.output_control_bit;
      end
      else if (run)
      begin
         cnt_d = nxt;
         if (single)
         begin
            if (am)
            begin
               on_d = 1'b0;
               af_d = 1'b1;
            end
         end
         else if (pwm)
         begin
            if (pm)
               cnt_d = CNT_RESET;
            if (pm)
               pf_d = 1'b1;
            if (am)
               af_d = 1'b1;
         end
         else
         begin
            if (am)
               af_d = 1'b1;
            if (ctrl_q.clear_select_bit)
            begin
               if (am)
                  cnt_d = CNT_RESET;
            end
            else if (pm)
            begin
               cnt_d = CNT_RESET;
               pf_d = 1'b1;
            end
            if (am)
            begin
               unique case (ctrl_q.output_function_field)
                  FN_INACT: pin_d = pin_q;
                  FN_ACT: pin_d = 1'b0;
                  FN_PWM: pin_d = 1'b1;
                  FN_PULSE: pin_d = ~pin_q;
               endcase
            end
         end
      end
      // Pin edge start beats any software write in the same cycle
      if (ext_edge)
         on_d = 1'b1;
   end

   // Output group: pin level and drive enable
   always_comb
   begin
      // Full duty when A reaches a nonzero period; a zero period never saturates
      full = (p_q != CMP_RESET) & (a_q >= p_q);
      raw = full | (cnt_q < a_q);
      out_d = 1'b0;
      oe_d = 1'b0;
      if (single)
      begin
         out_d = (on_q ? ctrl_q.output_control_bit : ~ctrl_q.output_control_bit)
            ^ ctrl_q.output_polarity_bit;
         oe_d = 1'b1;
      end
      else if (pwm)
      begin
         unique case (ctrl_q.output_function_field)
            FN_INACT: out_d = ~ctrl_q.output_control_bit;
            FN_ACT: out_d = ctrl_q.output_control_bit;
            default: out_d = raw ? ctrl_q.output_control_bit : ~ctrl_q.output_control_bit;
         endcase
         out_d = out_d ^ ctrl_q.output_polarity_bit;
         oe_d = 1'b1;
      end
      else if (ctrl_q.mode_field == MODE_CMP)
      begin
         out_d = pin_q ^ ctrl_q.output_polarity_bit;
         oe_d = 1'b1;
      end
      // Timer/counter and capture settings leave the pin undriven
   end

   always_ff @(posedge clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ctrl_q <= CTRL_RESET;
         on_q <= 1'b0;
         on_prev_q <= 1'b0;
         ext_prev_q <= 1'b0;
         cnt_q <= CNT_RESET;
         a_q <= CMP_RESET;
         p_q <= CMP_RESET;
         af_q <= 1'b0;
         pf_q <= 1'b0;
         pin_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         on_q <= on_d;
         on_prev_q <= on_prev_d;
         ext_prev_q <= ext_prev_d;
         cnt_q <= cnt_d;
         a_q <= a_d;
         p_q <= p_d;
         af_q <= af_d;
         pf_q <= pf_d;
         pin_q <= pin_d;
      end
   end

   // Pin and enable are registered so the top outputs come straight from flops
   always_ff @(posedge clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         out_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign out_pin_out = out_q;
   assign out_en_out = oe_q;
   assign flag_a_out = af_q;
   assign flag_p_out = pf_q;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_q);

   sequence s_start;
      ext_edge ##1 on_q;
   endsequence

   sequence s_full;
      (pwm && ctrl_q.output_function_field == FN_PWM && full && !wr)
         ##1 (pwm && ctrl_q.output_function_field == FN_PWM && full);
   endsequence

   sequence s_bus_setup;
      setup ##1 (psel_in && penable_in);
   endsequence

   a_hi_byte_zero: assert property (setup && paddr_in == OFS_CNT_HI |=> prdata_q[31:2] == 30'h0 && prdata_q[1:0] == $past(cnt_q[9:8]))
      else $error("counter high byte read wrong");
   a_rise_clears: assert property ($rose(on_q) |=> cnt_q == CNT_RESET)
      else $error("counter not cleared on start");
   a_off_freezes: assert property (!on_q |=> cnt_q == $past(cnt_q))
      else $error("counter moved while off");
   a_tick_counts: assert property (run && nxt != p_q && nxt != a_q && nxt != CNT_RESET |=> cnt_q == $past(nxt))
      else $error("counter did not step by one");
   a_pwm_period: assert property (pwm && pm |=> cnt_q == CNT_RESET && pf_q)
      else $error("pwm period clear or flag missing");
   a_pulse_stop: assert property (single && am && !ext_edge |=> !on_q && af_q)
      else $error("single pulse did not stop on compare A");
   a_tc_undriven: assert property (ctrl_q.mode_field == MODE_TC |=> !out_en_out)
      else $error("pin driven in timer counter mode");
   a_clr_no_pflag: assert property (cmp_like && ctrl_q.clear_select_bit && !pf_q && !wr |=> !pf_q)
      else $error("compare P flag raised with clear select high");
   a_pin_start: assert property (s_start |=> cnt_q == CNT_RESET)
      else $error("pin edge did not start the counter");
   a_full_duty: assert property (s_full |-> out_pin_out == (ctrl_q.output_control_bit ^ ctrl_q.output_polarity_bit))
      else $error("full duty output not active");
   a_cmp_pin_load: assert property (ctrl_q.mode_field == MODE_CMP && on_rise |=> pin_q == $past(ctrl_q.output_control_bit))
      else $error("pin not loaded on start");
   a_bus_answer: assert property (s_bus_setup |-> pready_out)
      else $error("bus access not answered");
   a_ready_once: assert property (pready_out |=> !pready_out)
      else $error("ready stood longer than one cycle");
   a_unmapped_err: assert property (setup && paddr_in > OFS_FLAGS |=> pslverr_out)
      else $error("unmapped address gave no error");
   a_cmp_no_aflag: assert property (cmp_like && a_q == CMP_RESET && !af_q |=> !af_q)
      else $error("compare A flag raised with A zero");
   a_cmp_overflow: assert property (run && cmp_like && &cnt_q |=> cnt_q == CNT_RESET)
      else $error("counter did not wrap at its maximum");
   a_pin_hold: assert property (!am && !on_rise |=> pin_q == $past(pin_q))
      else $error("pin level moved without compare A match");
   a_cmp_toggle: assert property (
      cmp_like && am && ctrl_q.output_function_field == FN_PULSE |=> pin_q != $past(pin_q))
      else $error("pin did not toggle on compare A match");
   a_pwm_low: assert property (
      pwm && ctrl_q.output_function_field == FN_PWM && !full && cnt_q >= a_q && !wr
      |=> out_pin_out == (!ctrl_q.output_control_bit ^ ctrl_q.output_polarity_bit))
      else $error("pwm output active past duty");
   a_pwm_keep: assert property (pwm && am && !pm |=> cnt_q == $past(nxt))
      else $error("pwm counter cleared on compare A");
   a_pulse_count: assert property (single && run |=> cnt_q == $past(nxt))
      else $error("single pulse counter cleared while running");
   a_pulse_idle: assert property (
      single && !on_q && !wr
      |=> out_pin_out == (!ctrl_q.output_control_bit ^ ctrl_q.output_polarity_bit))
      else $error("single pulse output active while off");
   a_ext_ignored: assert property (!single && !wr |=> on_q == $past(on_q))
      else $error("on bit moved outside single pulse setting");
endmodule
`default_nettype wire

// ### prt_pkg.sv
// Shared constants and types for the periodic timer block
package prt_pkg;
   localparam int CW = 10;
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CNT_LO = 8'h08;
   localparam logic [7:0] OFS_CNT_HI = 8'h0c;
   localparam logic [7:0] OFS_A_LO = 8'h10;
   localparam logic [7:0] OFS_A_HI = 8'h14;
   localparam logic [7:0] OFS_P_LO = 8'h18;
   localparam logic [7:0] OFS_P_HI = 8'h1c;
   localparam logic [7:0] OFS_FLAGS = 8'h20;
   localparam int ON_BIT = 0;
   localparam int AF_BIT = 0;
   localparam int PF_BIT = 1;
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_CAP = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TC = 2'h3;
   localparam logic [1:0] FN_INACT = 2'h0;
   localparam logic [1:0] FN_ACT = 2'h1;
   localparam logic [1:0] FN_PWM = 2'h2;
   localparam logic [1:0] FN_PULSE = 2'h3;
   localparam logic [CW-1:0] CNT_RESET = 10'h000;
   localparam logic [CW-1:0] CMP_RESET = 10'h000;
   localparam logic [CW-1:0] CNT_ONE = 10'h001;

   // Control one layout, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] mode_field;
      logic [1:0] output_function_field;
      logic output_control_bit;
      logic output_polarity_bit;
      logic spare_bit;
      logic clear_select_bit;
   } prt_ctrl_t;

   localparam prt_ctrl_t CTRL_RESET = 8'h00;
endpackage

// ### prt_timer_tb.sv
// Self-checking testbench for the periodic timer block
`timescale 1ns/10ps
`default_nettype none
module tb;
   import prt_pkg::*;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic tick = 1'b0;
   logic ext_pin = 1'b0;
   logic [31:0] rdata;
   logic rerr;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, pin, pin_en, fa, fp;
   int fail_count = 0;
   int checks_done = 0;

   always #2 clk_in = ~clk_in;

   prt_timer DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .tick_in(tick),
      .ext_pin_in(ext_pin), .out_pin_out(pin), .out_en_out(pin_en), .flag_a_out(fa),
      .flag_p_out(fp));

   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Request held from setup edge until pready is seen; a stuck slave ends the run
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk_in);
         n++;
      end
      if (pready !== 1'b1)
      begin
         fail_count++;
         $display("[FAIL] apb ready expected 1 seen %b", pready);
         finish_test();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task ticks(input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         tick <= 1'b1;
         @(posedge clk_in);
         tick <= 1'b0;
      end
   endtask

   // Timer is stopped before reconfiguring, as the mode bits must not change while running
   task setup(input logic [7:0] c, input logic [7:0] a, input logic [7:0] p);
      apb(1'b1, OFS_CTRL0, 32'h0);
      apb(1'b1, OFS_FLAGS, 32'h3);
      apb(1'b1, OFS_CTRL1, {24'h000000, c});
      apb(1'b1, OFS_A_LO, {24'h000000, a});
      apb(1'b1, OFS_P_LO, {24'h000000, p});
   endtask

   task t_regs;
      apb(1'b0, OFS_CNT_HI, 32'h0);
      chk("counter high reset", 32'h0, rdata);
      apb(1'b0, OFS_A_HI, 32'h0);
      chk("compare a high reset", 32'h0, rdata);
      apb(1'b1, OFS_A_HI, 32'hffffffff);
      apb(1'b0, OFS_A_HI, 32'h0);
      chk("compare a high bits", 32'h3, rdata);
      apb(1'b1, OFS_P_HI, 32'hffffffff);
      apb(1'b0, OFS_P_HI, 32'h0);
      chk("compare p high bits", 32'h3, rdata);
      apb(1'b1, OFS_A_HI, 32'h0);
      apb(1'b1, OFS_P_HI, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, rerr});
   endtask

   task t_cmp;
      setup({MODE_CMP, FN_PULSE, 4'h9}, 8'h04, 8'h02);
      apb(1'b1, OFS_CTRL0, 32'h1);
      repeat (3) @(posedge clk_in);
      chk("initial pin level", 32'h1, {31'h0, pin});
      ticks(4);
      repeat (3) @(posedge clk_in);
      chk("toggled pin", 32'h0, {31'h0, pin});
      chk("compare a flag", 32'h1, {31'h0, fa});
      chk("no p flag", 32'h0, {31'h0, fp});
      chk("compare pin driven", 32'h1, {31'h0, pin_en});
   endtask

   task t_tc;
      setup({MODE_TC, FN_INACT, 4'h0}, 8'h01, 8'h02);
      apb(1'b1, OFS_CTRL0, 32'h1);
      ticks(4);
      repeat (3) @(posedge clk_in);
      chk("counter mode a flag", 32'h1, {31'h0, fa});
      chk("counter mode p flag", 32'h1, {31'h0, fp});
      chk("counter mode pin idle", 32'h0, {31'h0, pin_en});
   endtask

   task pwm_run(input logic [7:0] c, input logic [7:0] a, input logic [7:0] p,
      output int h);
      setup(c, a, p);
      apb(1'b1, OFS_CTRL0, 32'h1);
      @(posedge clk_in);
      tick <= 1'b1;
      repeat (10) @(posedge clk_in);
      h = 0;
      repeat (20)
      begin
         @(posedge clk_in);
         h += int'(pin);
      end
      tick <= 1'b0;
   endtask

   // Twenty cycles span whole periods of five, so the high count is phase independent
   task t_pwm;
      int h;
      pwm_run({MODE_PWM, FN_PWM, 4'h8}, 8'h03, 8'h05, h);
      chk("pwm high cycles", 32'd12, h);
      chk("pwm a flag", 32'h1, {31'h0, fa});
      chk("pwm p flag", 32'h1, {31'h0, fp});
      pwm_run({MODE_PWM, FN_PWM, 4'h8}, 8'h07, 8'h05, h);
      chk("pwm full duty", 32'd20, h);
      pwm_run({MODE_PWM, FN_INACT, 4'h8}, 8'h03, 8'h05, h);
      chk("pwm forced inactive", 32'd0, h);
      pwm_run({MODE_PWM, FN_ACT, 4'h8}, 8'h03, 8'h05, h);
      chk("pwm forced active", 32'd20, h);
      pwm_run({MODE_PWM, FN_ACT, 4'hc}, 8'h03, 8'h05, h);
      chk("pwm inverted active", 32'd0, h);
   endtask

   task t_pulse;
      setup({MODE_PWM, FN_PULSE, 4'h8}, 8'h03, 8'h00);
      @(posedge clk_in);
      ext_pin <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk("pulse leading edge", 32'h1, {31'h0, pin});
      apb(1'b0, OFS_CTRL0, 32'h0);
      chk("pulse on bit set", 32'h1, {31'h0, rdata[ON_BIT]});
      ticks(3);
      repeat (3) @(posedge clk_in);
      chk("pulse trailing edge", 32'h0, {31'h0, pin});
      chk("pulse a flag", 32'h1, {31'h0, fa});
      apb(1'b0, OFS_CTRL0, 32'h0);
      chk("pulse on bit cleared", 32'h0, {31'h0, rdata[ON_BIT]});
      ext_pin <= 1'b0;
   endtask

   // Free run with A zero: the counter passes 300, then wraps after 1024 ticks
   task t_wide;
      setup({MODE_CMP, FN_INACT, 4'h1}, 8'h00, 8'h00);
      apb(1'b1, OFS_CTRL0, 32'h1);
      ticks(300);
      apb(1'b0, OFS_CNT_HI, 32'h0);
      chk("counter high byte", 32'h1, rdata);
      apb(1'b0, OFS_CNT_LO, 32'h0);
      chk("counter low byte", 32'h2c, rdata);
      ticks(724);
      apb(1'b0, OFS_CNT_HI, 32'h0);
      chk("counter wrapped", 32'h0, rdata);
      chk("no a flag at a zero", 32'h0, {31'h0, fa});
      chk("no p flag with clear select", 32'h0, {31'h0, fp});
   endtask

   initial
   begin
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      t_regs();
      t_cmp();
      t_tc();
      t_pwm();
      t_pulse();
      t_wide();
      finish_test();
   end
endmodule
`default_nettype wire
